// *** verilog/tx_shaper_defs.vh ***
`ifndef TX_SHAPER_DEFS_VH
`define TX_SHAPER_DEFS_VH
// Register offsets
`define OFS_GLOBAL_CONFIG  8'h02
`define OFS_TX_CONFIG_0    8'h05
`define OFS_TX_TEMPLATE    8'h06
`define OFS_TX_SCALE       8'h07
`define OFS_WAVE_CTRL      8'h08
`define OFS_WAVE_DATA      8'h09
`define OFS_INT_MASK_1     8'h15
`define OFS_INT_STATUS_1   8'h1a
// Field positions
`define BIT_LINE_STANDARD  0
`define BIT_TX_FMT_LO      0
`define BIT_TX_FMT_HI      1
`define BIT_TX_INVERT      2
`define BIT_TX_EDGE        3
`define BIT_WAVE_RW        6
`define BIT_WAVE_DONE      7
`define BIT_INT_OVERFLOW   0
`define BIT_INT_CLK_LOSS   1
// Reset values
`define RST_GLOBAL_CONFIG  1'b0
`define RST_TX_CONFIG_0    4'h0
`define RST_TX_TEMPLATE    4'h0
`define RST_TX_SCALE       6'h21
`define RST_WAVE_CTRL      8'h00
`define RST_WAVE_DATA      7'h00
`define RST_INT_MASK       2'h0
// Timing counts
`define TX_LINE_CLOCK_LOSS_CYCLES   7'd70
`define SUBPHASE_CYCLES    2'd3
// Scale references: unscaled code for E1 and T1
`define SCALE_REF_E1       11'sd33
`define SCALE_REF_T1       11'sd54
// Preset template shape values
`define E1_75_EDGE         7'd12
`define E1_75_PEAK         7'd48
`define E1_120_EDGE        7'd15
`define E1_120_PEAK        7'd60
`define T1_ROM_PEAK        7'd39
`define T1_ROM_DIP         7'd10
`define T1_ROM_TAIL        7'd2
`endif

// *** verilog/line_encoder.v ***
module line_encoder (
  input  wire clk,      // System clock
  input  wire rst_n,    // Async reset, active low
  input  wire bitEn,    // One bit time step
  input  wire dataIn,   // Single-rail data
  input  wire substOn,  // Zero substitution on
  input  wire t1Mode,   // 1 B8ZS, 0 HDB3
  output reg  pulsePos, // Positive mark
  output reg  pulseNeg  // Negative mark
);
  localparam MK_B = 2'b01;
  localparam MK_V = 2'b10;
  reg  [15:0] mark;
  reg         lastPol;
  reg         oddCount;
  wire [15:0] shifted = {mark[13:0], dataIn ? MK_B : 2'b00};
  wire        b8zsHit = substOn && t1Mode && (shifted == 16'h0000);
  wire        hdb3Hit = substOn && !t1Mode && (shifted[7:0] == 8'h00);
  reg  [15:0] next_mark;
  always @* begin
    next_mark = shifted;
    if (b8zsHit) begin
      next_mark = {6'h00, MK_V, MK_B, 2'b00, MK_V, MK_B};
    end else if (hdb3Hit) begin
      next_mark[7:0] = oddCount ? {6'h00, MK_V} : {MK_B, 4'h0, MK_V};
    end
  end
  // Eight-bit delay line lets B8ZS look ahead; AMI and HDB3 share it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mark     <= 16'h0000;
      lastPol  <= 1'b0;
      oddCount <= 1'b0;
      pulsePos <= 1'b0;
      pulseNeg <= 1'b0;
    end else if (bitEn) begin
      mark     <= next_mark;
      oddCount <= hdb3Hit ? 1'b0 : (oddCount ^ dataIn);
      if (mark[15:14] == MK_B) begin
        lastPol  <= ~lastPol;
        pulsePos <= ~lastPol;
        pulseNeg <= lastPol;
      end else if (mark[15:14] == MK_V) begin
        pulsePos <= lastPol;
        pulseNeg <= ~lastPol;
      end else begin
        pulsePos <= 1'b0;
        pulseNeg <= 1'b0;
      end
    end
  end
endmodule // line_encoder

// *** verilog/pulse_shaper.v ***
`include "tx_shaper_defs.vh"
module pulse_shaper (
  input  wire       clk,       // System clock
  input  wire       rst_n,     // Async reset, active low
  input  wire       symEn,     // New symbol
  input  wire       symPos,    // Positive pulse
  input  wire       symNeg,    // Negative pulse
  input  wire       arbMode,   // Use wave memory
  input  wire [2:0] romSel,    // Preset template
  input  wire       t1Mode,    // T1/J1 scale reference
  input  wire [5:0] scale,     // Amplitude scale
  input  wire       ramReq,    // Memory access pulse
  input  wire       ramWrite,  // 1 write, 0 read
  input  wire [5:0] ramAddr,   // Interval, sub-phase
  input  wire [6:0] ramWrData, // Sample to store
  output reg        ramAck,    // Access done pulse
  output reg  [6:0] ramRdData, // Sample read
  output reg  [6:0] amplitude, // Signed-magnitude level
  output reg        overflow   // Saturation pulse
);
  reg  [6:0] wave [0:63];
  reg  [3:0] histP;
  reg  [3:0] histN;
  reg  [3:0] subPhase;
  reg  [1:0] subCnt;
  wire signed [9:0] part [0:3];
  function [6:0] romSample;
    input [2:0] sel;
    input [1:0] ui;
    input [3:0] sp;
    begin
      romSample = 7'h00;
      if (sel[2:1] == 2'b00) begin
        if (ui == 2'd0 && sp == 4'd3) romSample = sel[0] ? `E1_120_EDGE : `E1_75_EDGE;
        if (ui == 2'd0 && sp >= 4'd4 && sp <= 4'd11) begin
          romSample = sel[0] ? `E1_120_PEAK : `E1_75_PEAK;
        end
      end else if (ui == 2'd0) begin
        // Sign bit is OR-ed in so the magnitude keeps its 6-bit width
        romSample = (sp <= 4'd8) ? `T1_ROM_PEAK : (7'h40 | `T1_ROM_DIP);
      end else if (ui == 2'd1 && sp <= 4'd1) begin
        romSample = 7'h40 | `T1_ROM_TAIL;
      end
    end
  endfunction
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_ui
      localparam [1:0] UI = k;
      wire [6:0] s = arbMode ? wave[{UI, subPhase}] : romSample(romSel, UI, subPhase);
      wire signed [9:0] v = s[6] ? -$signed({4'h0, s[5:0]}) : $signed({4'h0, s[5:0]});
      assign part[k] = histP[k] ? v : (histN[k] ? -v : 10'sd0);
    end
  endgenerate
  wire signed [9:0]  sum    = part[0] + part[1] + part[2] + part[3];
  wire signed [16:0] prod   = sum * $signed({1'b0, scale});
  wire signed [16:0] scaled = t1Mode ? prod / `SCALE_REF_T1 : prod / `SCALE_REF_E1;
  wire signed [16:0] level  = arbMode ? scaled : {{7{sum[9]}}, sum};
  wire               over   = (level > 17'sd63) || (level < -17'sd63);
  wire [16:0]        mag    = level[16] ? -level : level;
  always @(posedge clk) begin
    if (ramReq && ramWrite) begin
      wave[ramAddr] <= ramWrData;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramAck    <= 1'b0;
      ramRdData <= 7'h00;
      histP     <= 4'h0;
      histN     <= 4'h0;
      subPhase  <= 4'h0;
      subCnt    <= 2'd0;
      amplitude <= 7'h00;
      overflow  <= 1'b0;
    end else begin
      ramAck <= ramReq;
      if (ramReq && !ramWrite) begin
        ramRdData <= wave[ramAddr];
      end
      if (symEn) begin
        histP    <= {histP[2:0], symPos};
        histN    <= {histN[2:0], symNeg};
        subPhase <= 4'h0;
        subCnt   <= 2'd0;
      end else if (subCnt == `SUBPHASE_CYCLES - 2'd1) begin
        subCnt <= 2'd0;
        // Holds the last sub-phase if the bit is longer than 16 steps
        if (subPhase != 4'hf) subPhase <= subPhase + 4'h1;
      end else begin
        subCnt <= subCnt + 2'd1;
      end
      overflow  <= over;
      amplitude <= over ? {level[16], 6'h3f} : {level[16], mag[5:0]};
    end
  end
endmodule // pulse_shaper

// *** verilog/tx_path_pulse_shaper.v ***
`include "tx_shaper_defs.vh"
module tx_path_pulse_shaper (
  input  wire       clk,              // 100 MHz master clock
  input  wire       rst_n,            // Async reset, active low
  input  wire [1:0] controlModePins,  // Control interface select pins
  input  wire       serialEdgeSelect, // Serial clock edge select pin
  input  wire [3:0] templatePins,     // Pulse template select pins
  input  wire [1:0] pathModePins,     // Path mode select pins
  input  wire       txLineClock,      // Transmit line clock pin
  input  wire       txDataPositive,   // Data or positive rail pin
  input  wire       txDataNegative,   // Negative rail pin
  input  wire [7:0] regAddr,          // Register offset
  input  wire       regWrEn,          // Register write strobe
  input  wire       regRdEn,          // Register read strobe
  input  wire [7:0] regWrData,        // Register write data
  output reg  [7:0] regRdData,        // Register read data
  output reg  [3:0] controlInterface, // One-hot control mode
  output reg        serialRisingEdge, // Serial port uses rising edge
  output reg  [1:0] pathMode,         // Receive/transmit path mode
  output reg        t1Standard,       // 1 T1/J1, 0 E1
  output reg  [1:0] terminationSel,   // Termination choice
  output wire [6:0] lineDriverPair,   // Signed-magnitude line level
  output reg        irq               // Interrupt, active high
);
  localparam CI_HW       = 4'b0001;
  localparam CI_SERIAL   = 4'b0010;
  localparam CI_PAR_MOTO = 4'b0100;
  localparam CI_PAR_STRB = 4'b1000;
  localparam TERM_75     = 2'd0;
  localparam TERM_120    = 2'd1;
  localparam TERM_100    = 2'd2;
  localparam TERM_110    = 2'd3;
  localparam TPL_E1_75   = 4'h0;
  localparam TPL_E1_120  = 4'h1;
  localparam TPL_J1      = 4'h7;

  // Two-flop synchronisers for every pin
  reg [11:0] pinMeta;
  reg [11:0] pinSync;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 12'h000;
      pinSync <= 12'h000;
    end else begin
      pinMeta <= {controlModePins, serialEdgeSelect, templatePins, pathModePins,
                  txLineClock, txDataPositive, txDataNegative};
      pinSync <= pinMeta;
    end
  end
  wire [1:0] modeS   = pinSync[11:10];
  wire       sEdgeS  = pinSync[9];
  wire [3:0] tplPinS = pinSync[8:5];
  wire [1:0] pathS   = pinSync[4:3];
  wire       tclkS   = pinSync[2];
  wire       dataPS  = pinSync[1];
  wire       dataNS  = pinSync[0];

  // Registers
  reg       lineStandard;
  reg [3:0] txConfig;
  reg [3:0] templateSel;
  reg [5:0] scaleField;
  reg [7:0] waveCtrl;
  reg [6:0] waveData;
  reg [1:0] intMask;
  reg [1:0] intStatus;

  wire hwMode = (modeS == 2'b00);
  wire [3:0] effTemplate = hwMode ? tplPinS : templateSel;
  wire effT1 = hwMode ? !(effTemplate == TPL_E1_75 || effTemplate == TPL_E1_120)
                      : lineStandard;
  wire [1:0] effFormat  = hwMode ? pathS : txConfig[`BIT_TX_FMT_HI:`BIT_TX_FMT_LO];
  wire       effInvert  = hwMode ? 1'b0 : txConfig[`BIT_TX_INVERT];
  wire       effRising  = hwMode ? 1'b0 : txConfig[`BIT_TX_EDGE];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controlInterface <= CI_HW;
      serialRisingEdge <= 1'b0;
      pathMode         <= 2'b00;
      t1Standard       <= 1'b0;
      terminationSel   <= TERM_75;
    end else begin
      case (modeS)
        2'b00:   controlInterface <= CI_HW;
        2'b01:   controlInterface <= CI_SERIAL;
        2'b10:   controlInterface <= CI_PAR_MOTO;
        default: controlInterface <= CI_PAR_STRB;
      endcase
      serialRisingEdge <= (modeS == 2'b01) && sEdgeS;
      pathMode         <= hwMode ? pathS : 2'b00;
      t1Standard       <= effT1;
      if (effTemplate == TPL_E1_75) terminationSel <= TERM_75;
      else if (effTemplate == TPL_E1_120) terminationSel <= TERM_120;
      else if (effTemplate == TPL_J1) terminationSel <= TERM_110;
      else terminationSel <= TERM_100;
    end
  end

  // Transmit clock edges and loss watch
  reg       tclkPrev;
  reg [6:0] gapCnt;
  wire tclkRise  = tclkS && !tclkPrev;
  wire tclkFall  = !tclkS && tclkPrev;
  wire bitEn     = effRising ? tclkRise : tclkFall;
  wire clkLost   = (gapCnt == `TX_LINE_CLOCK_LOSS_CYCLES) && !tclkRise && !tclkFall;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tclkPrev <= 1'b0;
      gapCnt   <= 7'd0;
    end else begin
      tclkPrev <= tclkS;
      if (tclkRise || tclkFall) gapCnt <= 7'd0;
      else if (gapCnt <= `TX_LINE_CLOCK_LOSS_CYCLES) gapCnt <= gapCnt + 7'd1;
    end
  end

  // Data sampling and rail handling
  wire dataP     = dataPS ^ effInvert;
  wire dataN     = dataNS ^ effInvert;
  wire dualRail  = effFormat[1];
  wire substOn   = effFormat[0];
  wire encPos;
  wire encNeg;
  reg  dualPos;
  reg  dualNeg;
  reg  symEn;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dualPos <= 1'b0;
      dualNeg <= 1'b0;
      symEn   <= 1'b0;
    end else begin
      symEn <= bitEn;
      if (bitEn) begin
        dualPos <= !dataP && dataN;
        dualNeg <= dataP && !dataN;
      end
    end
  end
  line_encoder u_enc (
    .clk      (clk),
    .rst_n    (rst_n),
    .bitEn    (bitEn && !dualRail),
    .dataIn   (dataP),
    .substOn  (substOn),
    .t1Mode   (effT1),
    .pulsePos (encPos),
    .pulseNeg (encNeg)
  );
  wire symPos = dualRail ? dualPos : encPos;
  wire symNeg = dualRail ? dualNeg : encNeg;

  // Wave memory access sequencing
  reg  ramReq;
  wire ramAck;
  wire [6:0] ramRdData;
  wire overflow;
  pulse_shaper u_shp (
    .clk       (clk),
    .rst_n     (rst_n),
    .symEn     (symEn),
    .symPos    (symPos),
    .symNeg    (symNeg),
    .arbMode   (effTemplate[3:2] == 2'b11),
    .romSel    (effTemplate[2:0]),
    .t1Mode    (effT1),
    .scale     (scaleField),
    .ramReq    (ramReq),
    .ramWrite  (!waveCtrl[`BIT_WAVE_RW]),
    .ramAddr   (waveCtrl[5:0]),
    .ramWrData (waveData),
    .ramAck    (ramAck),
    .ramRdData (ramRdData),
    .amplitude (lineDriverPair),
    .overflow  (overflow)
  );

  // Register write side
  wire wrHit = regWrEn;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineStandard <= `RST_GLOBAL_CONFIG;
      txConfig     <= `RST_TX_CONFIG_0;
      templateSel  <= `RST_TX_TEMPLATE;
      scaleField   <= `RST_TX_SCALE;
      waveCtrl     <= `RST_WAVE_CTRL;
      waveData     <= `RST_WAVE_DATA;
      intMask      <= `RST_INT_MASK;
      ramReq       <= 1'b0;
    end else begin
      ramReq <= wrHit && (regAddr == `OFS_WAVE_CTRL) && regWrData[`BIT_WAVE_DONE];
      if (ramAck) begin
        waveCtrl[`BIT_WAVE_DONE] <= 1'b0;
        if (waveCtrl[`BIT_WAVE_RW]) waveData <= ramRdData;
      end
      if (wrHit) begin
        case (regAddr)
          `OFS_GLOBAL_CONFIG: lineStandard <= regWrData[`BIT_LINE_STANDARD];
          `OFS_TX_CONFIG_0:   txConfig     <= regWrData[3:0];
          `OFS_TX_TEMPLATE:   templateSel  <= regWrData[3:0];
          `OFS_TX_SCALE:      scaleField   <= regWrData[5:0];
          `OFS_WAVE_CTRL:     waveCtrl     <= regWrData;
          `OFS_WAVE_DATA:     waveData     <= regWrData[6:0];
          `OFS_INT_MASK_1:    intMask      <= regWrData[1:0];
          default:            ;
        endcase
      end
    end
  end

  // Status: read clears, a new event in the same cycle wins
  wire       stsRead = regRdEn && (regAddr == `OFS_INT_STATUS_1);
  wire [1:0] events  = {clkLost, overflow};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intStatus <= 2'b00;
      irq       <= 1'b0;
    end else begin
      intStatus <= (stsRead ? 2'b00 : intStatus) | events;
      irq       <= |(intStatus & intMask);
    end
  end

  // Register read side
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `OFS_GLOBAL_CONFIG: regRdData <= {7'h00, lineStandard};
        `OFS_TX_CONFIG_0:   regRdData <= {4'h0, txConfig};
        `OFS_TX_TEMPLATE:   regRdData <= {4'h0, templateSel};
        `OFS_TX_SCALE:      regRdData <= {2'b00, scaleField};
        `OFS_WAVE_CTRL:     regRdData <= waveCtrl;
        `OFS_WAVE_DATA:     regRdData <= {1'b0, waveData};
        `OFS_INT_MASK_1:    regRdData <= {6'h00, intMask};
        `OFS_INT_STATUS_1:  regRdData <= {6'h00, intStatus};
        default:            regRdData <= 8'h00;
      endcase
    end
  end
endmodule // tx_path_pulse_shaper

// *** dv/tx_path_pulse_shaper_assertions.sv ***
module tx_path_pulse_shaper_checker (
  input logic       clk,              // Master clock
  input logic       rst_n,            // Async reset, active low
  input logic [1:0] controlModePins,  // Control select pins
  input logic       txLineClock,      // Line clock pin
  input logic [7:0] regAddr,          // Register offset
  input logic       regWrEn,          // Write strobe
  input logic       regRdEn,          // Read strobe
  input logic [7:0] regWrData,        // Write data
  input logic [7:0] regRdData,        // Read data
  input logic [3:0] controlInterface, // One-hot mode
  input logic       serialRisingEdge, // Serial edge
  input logic [1:0] pathMode,         // Path mode
  input logic       t1Standard,       // Line standard
  input logic       irq               // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] gapCnt;
  logic       prevClk;
  logic       lossEn;
  logic       ovEn;
  wire        waveGo = regWrEn && regAddr == 8'h08 && regWrData[7];
  // Raw pin gap; slack up to 80 covers the synchroniser lag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt  <= 8'h00;
      prevClk <= 1'b0;
      lossEn  <= 1'b0;
      ovEn    <= 1'b0;
    end else begin
      prevClk <= txLineClock;
      if (txLineClock != prevClk)
        gapCnt <= 8'h00;
      else if (gapCnt != 8'hff)
        gapCnt <= gapCnt + 8'h01;
      if (regWrEn && regAddr == 8'h15) begin
        lossEn <= regWrData[1];
        ovEn   <= regWrData[0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ctrlOneHot;
    $onehot(controlInterface);
  endproperty
  a_ctrlOneHot: assert property (p_ctrlOneHot) else $error("mode not one-hot");
  property p_ctrlDecode;
    $stable(controlModePins) [*5] |-> controlInterface == (4'h1 << controlModePins);
  endproperty
  a_ctrlDecode: assert property (p_ctrlDecode) else $error("mode decode wrong");
  property p_serialEdge;
    serialRisingEdge |-> controlInterface == 4'h2;
  endproperty
  a_serialEdge: assert property (p_serialEdge) else $error("serial edge outside serial");
  property p_pathMode;
    pathMode != 2'b00 |-> controlInterface == 4'h1;
  endproperty
  a_pathMode: assert property (p_pathMode) else $error("path mode outside hw mode");
  property p_swStandard;
    logic d;
    (regWrEn && regAddr == 8'h02 && controlInterface != 4'h1, d = regWrData[0])
      |-> ##3 t1Standard == d;
  endproperty
  a_swStandard: assert property (p_swStandard) else $error("standard not taken");
  property p_waveDone;
    regRdEn && regAddr == 8'h08 && !waveGo && !$past(waveGo) && !$past(waveGo, 2)
      && !$past(waveGo, 3) && !$past(waveGo, 4) |=> !regRdData[7];
  endproperty
  a_waveDone: assert property (p_waveDone) else $error("done bit stuck");
  property p_clockLoss;
    gapCnt == 8'd80 && lossEn |-> irq;
  endproperty
  a_clockLoss: assert property (p_clockLoss) else $error("clock loss not flagged");
  property p_irqMasked;
    (!lossEn && !ovEn) [*2] |-> !irq;
  endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("masked interrupt raised");
  c_waveAccess: cover property (waveGo);
  c_irq: cover property ($rose(irq));
  c_serial: cover property (serialRisingEdge);
endmodule // tx_path_pulse_shaper_checker

bind tx_path_pulse_shaper tx_path_pulse_shaper_checker chk_i (
  .clk, .rst_n, .controlModePins, .txLineClock, .regAddr, .regWrEn, .regRdEn,
  .regWrData, .regRdData, .controlInterface, .serialRisingEdge, .pathMode,
  .t1Standard, .irq
);

// *** dv/line_framer.sv ***
module line_framer (
  output logic txLineClock,    // Line clock toward device
  output logic txDataPositive, // Data or positive rail
  output logic txDataNegative  // Negative rail
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    txLineClock    = 1'b0;
    txDataPositive = 1'b1;
    txDataNegative = 1'b0;
  end
  // Data is right only near the active edge, so the wrong edge sees its inverse
  task sendSym(input logic p, n, rise);
    {txDataPositive, txDataNegative} = rise ? {p, n} : ~{p, n};
    #40 txLineClock = 1'b1;
    #20 {txDataPositive, txDataNegative} = rise ? ~{p, n} : {p, n};
    #20 txLineClock = 1'b0;
    #20 {txDataPositive, txDataNegative} = ~{p, n};
    // Clock stands still; gap keeps each symbol longer than one shaped pulse
    #420;
  endtask
endmodule // line_framer

// *** dv/tx_path_pulse_shaper_tb.sv ***
module tx_path_pulse_shaper_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a, e, m;} note_t;
  logic        clk;
  logic        rst_n;
  logic [1:0]  controlModePins;
  logic        serialEdgeSelect = 1'b1;
  logic [3:0]  templatePins;
  logic [1:0]  pathModePins;
  logic [7:0]  regAddr;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regWrData;
  logic        rdPend = 1'b0;
  logic [7:0]  posPk;
  logic [7:0]  negPk;
  logic [7:0]  v;
  logic [31:0] lfsr = 32'h320a;
  wire         txLineClock, txDataPositive, txDataNegative;
  wire  [7:0]  regRdData;
  wire  [3:0]  controlInterface;
  wire         serialRisingEdge, t1Standard, irq;
  wire  [1:0]  pathMode;
  wire  [1:0]  terminationSel;
  wire  [6:0]  lineDriverPair;
  note_t       notes[$];
  int          failCount;
  int          checksDone;
  int          cycles;
  logic [15:0] rv [8] = '{16'h0200, 16'h0500, 16'h0600, 16'h0721, 16'h0800, 16'h0900,
                          16'h1500, 16'h3000};
  // {config, template, scale, positive bits, negative bits, peak up, peak down}
  logic [55:0] tbl [8] = '{
    56'h02_00_00_01_00_00_30,
    56'h02_01_3f_00_01_3c_00,
    56'h02_00_21_01_01_00_00,
    56'h06_00_21_01_00_30_00,
    56'h0a_00_21_00_01_30_00,
    56'h00_00_21_03_00_30_30,
    56'h01_00_21_01_00_30_30,
    56'h82_07_36_00_01_27_0a};

  tx_path_pulse_shaper dut (.clk, .rst_n, .controlModePins, .serialEdgeSelect,
    .templatePins, .pathModePins, .txLineClock, .txDataPositive, .txDataNegative,
    .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData, .controlInterface,
    .serialRisingEdge, .pathMode, .t1Standard, .terminationSel, .lineDriverPair, .irq);
  line_framer framer (.txLineClock, .txDataPositive, .txDataNegative);

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction

  task chk(input string nm, input logic [7:0] e, g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, d);
    @(posedge clk) #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk) #1 regWrEn = 1'b0;
  endtask

  task rd(input logic [7:0] a, e, m);
    @(posedge clk) #1;
    notes.push_back(note_t'{a, e & m, m});
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk) #1 regRdEn = 1'b0;
  endtask

  task run(input logic [55:0] t);
    integer i;
    wr(8'h02, {7'h0, t[55]});
    wr(8'h05, {4'h0, t[51:48]});
    wr(8'h06, t[47:40]);
    wr(8'h07, t[39:32]);
    posPk = 8'h00;
    negPk = 8'h00;
    // Eight trailing spaces flush the single-rail delay line
    for (i = 0; i < 16; i++)
      framer.sendSym(i < 8 && t[24 + i], i < 8 && t[16 + i], t[51]);
    chk("positive peak", t[15:8], posPk);
    chk("negative peak", t[7:0], negPk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    rdPend <= regRdEn;
    if (lineDriverPair[6] && lineDriverPair[5:0] > negPk[5:0])
      negPk = {2'b00, lineDriverPair[5:0]};
    else if (!lineDriverPair[6] && lineDriverPair[5:0] > posPk[5:0])
      posPk = {2'b00, lineDriverPair[5:0]};
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      conclude;
    end
  end

  always @(negedge clk) begin : watch
    note_t n;
    if (rdPend) begin
      n = notes.pop_front();
      chk($sformatf("register %h", n.a), n.e, regRdData & n.m);
    end
  end

  initial begin : main
    integer i;
    rst_n = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    controlModePins = 2'b00;
    pathModePins = lfsr[1:0] | 2'b01;
    templatePins = lfsr[5:2];
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    chk("control mode", 8'h01, {4'h0, controlInterface});
    chk("path mode", {6'h0, pathModePins}, {6'h0, pathMode});
    chk("hw standard", {7'h0, templatePins > 4'h1}, {7'h0, t1Standard});
    chk("termination", {6'h0, templatePins == 4'h0 ? 2'd0 : templatePins == 4'h1 ? 2'd1 :
        templatePins == 4'h7 ? 2'd3 : 2'd2}, {6'h0, terminationSel});
    for (i = 3; i > 0; i--) begin
      #1 controlModePins = i[1:0];
      repeat (6) @(posedge clk);
      chk("control mode", 8'h01 << i, {4'h0, controlInterface});
      chk("serial edge", {7'h0, i == 1}, {7'h0, serialRisingEdge});
    end
    for (i = 0; i < 8; i++)
      rd(rv[i][15:8], rv[i][7:0], 8'hff);
    wr(8'h02, 8'h01);
    repeat (3) @(posedge clk);
    chk("standard", 8'h01, {7'h0, t1Standard});
    rd(8'h02, 8'h01, 8'hff);
    lfsr = nextRand(nextRand(lfsr));
    // Samples of 40 and up overflow once scaled by the largest code
    v = 8'h28 | {5'h00, lfsr[2:0]};
    for (i = 0; i < 64; i++) begin
      wr(8'h09, i == 5 ? v : 8'h00);
      wr(8'h08, 8'h80 | i[7:0]);
      repeat (3) @(posedge clk);
    end
    wr(8'h08, 8'hc5);
    repeat (4) @(posedge clk);
    rd(8'h08, 8'h45, 8'hff);
    rd(8'h09, v, 8'hff);
    for (i = 0; i < 8; i++)
      run(tbl[i]);
    run({40'h02_0c_21_00_01, v, 8'h00});
    run(56'h02_0c_00_00_01_00_00);
    run(56'h02_0c_3f_00_01_3f_00);
    rd(8'h1a, 8'h01, 8'h01);
    rd(8'h1a, 8'h00, 8'h01);
    framer.sendSym(1'b0, 1'b0, 1'b0);
    wr(8'h15, 8'h02);
    repeat (100) @(posedge clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    rd(8'h1a, 8'h02, 8'h02);
    wr(8'h15, 8'h00);
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule // tx_path_pulse_shaper_tb
